// ---- clock_out_divider.sv ----
// bus clock divider for the clock output pin
// assumes enable and select come from registers on the same clock
`timescale 1ns/1ps
module clock_out_divider (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic enable_i,
   input wire logic [2:0] divide_i,
   output logic clk_out_o,
   output logic drive_n_o
);
   logic [2:0] count_r;
   logic [2:0] divide_r;

   // restart on a select change so no runt half period
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         divide_r <= 3'h0;
      end else begin
         divide_r <= divide_i;
      end
   end

   // half period of divide bus cycles
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_r <= 3'h0;
         clk_out_o <= 1'b0;
      end else if (!enable_i || divide_i == 3'h0 || divide_i != divide_r) begin
         count_r <= 3'h0;
         clk_out_o <= 1'b0;
      end else if (count_r == divide_i - 3'h1) begin
         count_r <= 3'h0;
         clk_out_o <= ~clk_out_o;
      end else begin
         count_r <= count_r + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         drive_n_o <= 1'b1;
      end else begin
         drive_n_o <= ~enable_i;
      end
   end
endmodule : clock_out_divider

// ---- sysconf_pkg.sv ----
// constants shared by the system configuration block and its testbench
// assumes a 100 MHz bus clock and 8-bit registers on 32-bit word addresses
package sysconf_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_SYSTEM_OPTIONS = 8'h00;
   localparam logic [7:0] OFS_CLOCK_OUTPUT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_PART_ID_HIGH = 8'h08;
   localparam logic [7:0] OFS_PART_ID_LOW = 8'h0C;
   localparam logic [7:0] OFS_PERIODIC_WAKEUP_CONTROL = 8'h10;
   // system options fields
   localparam int WATCHDOG_ENABLE_BIT = 7;
   localparam int WATCHDOG_LONG_TIMEOUT_BIT = 6;
   localparam int STOP_ALLOW_BIT = 5;
   localparam logic [2:0] SYSTEM_OPTIONS_RESET = 3'b110;
   // clock output control fields
   localparam int CLOCK_OUT_PIN_ENABLE_BIT = 4;
   localparam int CLOCK_OUT_DIVIDE_LSB = 0;
   localparam logic [3:0] CLOCK_OUTPUT_CONTROL_RESET = 4'h0;
   // wakeup control fields
   localparam int WAKEUP_TIMEOUT_FLAG_BIT = 7;
   localparam int WAKEUP_TIMEOUT_ACK_BIT = 6;
   localparam int WAKEUP_CLOCK_SELECT_BIT = 5;
   localparam int WAKEUP_IRQ_ENABLE_BIT = 4;
   localparam int WAKEUP_DELAY_LSB = 0;
   localparam logic [4:0] WAKEUP_CONTROL_RESET = 5'h00;
   // identification, values arbitrary
   localparam logic [11:0] PART_NUMBER = 12'h0A5C;
   localparam logic [3:0] PART_REVISION = 4'h1;
   // internal oscillator rate and periods in ms
   localparam int LPO_FREQ_KHZ = 1;
   localparam int WAKE_MS_1 = 8;
   localparam int WAKE_MS_2 = 32;
   localparam int WAKE_MS_3 = 64;
   localparam int WAKE_MS_4 = 128;
   localparam int WAKE_MS_5 = 256;
   localparam int WAKE_MS_6 = 512;
   localparam int WAKE_MS_7 = 1024;
   // crystal periods in crystal cycles
   localparam int WAKE_XTAL_1 = 256;
   localparam int WAKE_XTAL_2 = 1024;
   localparam int WAKE_XTAL_3 = 2048;
   localparam int WAKE_XTAL_4 = 4096;
   localparam int WAKE_XTAL_5 = 8192;
   localparam int WAKE_XTAL_6 = 16384;
   localparam int WAKE_XTAL_7 = 32768;
   localparam int WAKE_CNT_W = 15;
endpackage : sysconf_pkg

// ---- system_options_wakeup_clkout.sv ----
// system options, clock output control, part id and periodic wakeup timer
// assumes a single AHB-Lite master; wakeup clocks arrive as slow pin levels
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module system_options_wakeup_clkout (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic LPO_CLK_I,
   input wire logic XTAL_CLK_I,
   input wire logic STOP_EXEC_I,
   output logic WATCHDOG_ENABLE_O,
   output logic WATCHDOG_LONG_TIMEOUT_O,
   output logic STOP_ALLOW_O,
   output logic STOP_ENTER_O,
   output logic ILLEGAL_OPCODE_RESET_O,
   output logic CLOCK_OUT_PORT_PIN_O,
   output logic CLOCK_OUT_PORT_PIN_OE_N_O,
   output logic WAKEUP_IRQ_O
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRITE = 3'b010,
      BUS_READ = 3'b100
   } bus_state_e;

   bus_state_e bus_state_r;
   logic [7:0] addr_r;
   logic [31:0] rdata_r;
   logic ready_r;
   logic accept;
   logic wr_en;
   logic [7:0] wdata;
   logic [7:0] read_mux;

   logic watchdog_enable_r;
   logic watchdog_long_timeout_r;
   logic stop_allow_r;
   logic options_written_r;
   logic clock_out_pin_enable_r;
   logic [2:0] clock_out_divide_select_r;
   logic wakeup_timeout_flag_r;
   logic wakeup_clock_select_r;
   logic wakeup_irq_enable_r;
   logic [2:0] wakeup_delay_select_r;
   logic irq_r;
   logic stop_enter_r;
   logic illegal_r;

   logic [2:0] lpo_sync_r;
   logic [2:0] xtal_sync_r;
   logic tick;
   logic [sysconf_pkg::WAKE_CNT_W-1:0] wake_count_r;
   logic [sysconf_pkg::WAKE_CNT_W-1:0] wake_last;
   logic wake_timeout;

   // address phase taken only for an active transfer on a ready bus
   assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign wr_en = (bus_state_r == BUS_WRITE);
   assign wdata = HWDATA_I[7:0];

   // reads take one wait state so a write just before is always visible
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         bus_state_r <= BUS_IDLE;
         addr_r <= 8'h00;
         ready_r <= 1'b1;
      end else begin
         case (bus_state_r)
            BUS_IDLE, BUS_WRITE: begin
               if (accept) begin
                  addr_r <= HADDR_I[7:0];
                  bus_state_r <= HWRITE_I ? BUS_WRITE : BUS_READ;
                  ready_r <= HWRITE_I;
               end else begin
                  bus_state_r <= BUS_IDLE;
                  ready_r <= 1'b1;
               end
            end
            BUS_READ: begin
               bus_state_r <= BUS_IDLE;
               ready_r <= 1'b1;
            end
            default: begin
               bus_state_r <= BUS_IDLE;
               ready_r <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      read_mux = 8'h00;
      case (addr_r)
         sysconf_pkg::OFS_SYSTEM_OPTIONS: begin
            read_mux[sysconf_pkg::WATCHDOG_ENABLE_BIT] = watchdog_enable_r;
            read_mux[sysconf_pkg::WATCHDOG_LONG_TIMEOUT_BIT] = watchdog_long_timeout_r;
            read_mux[sysconf_pkg::STOP_ALLOW_BIT] = stop_allow_r;
         end
         sysconf_pkg::OFS_CLOCK_OUTPUT_CONTROL: begin
            read_mux[sysconf_pkg::CLOCK_OUT_PIN_ENABLE_BIT] = clock_out_pin_enable_r;
            read_mux[sysconf_pkg::CLOCK_OUT_DIVIDE_LSB +: 3] = clock_out_divide_select_r;
         end
         // fixed id, revision in reserved bits
         sysconf_pkg::OFS_PART_ID_HIGH: begin
            read_mux = {sysconf_pkg::PART_REVISION, sysconf_pkg::PART_NUMBER[11:8]};
         end
         sysconf_pkg::OFS_PART_ID_LOW: begin
            read_mux = sysconf_pkg::PART_NUMBER[7:0];
         end
         sysconf_pkg::OFS_PERIODIC_WAKEUP_CONTROL: begin
            read_mux[sysconf_pkg::WAKEUP_TIMEOUT_FLAG_BIT] = wakeup_timeout_flag_r;
            read_mux[sysconf_pkg::WAKEUP_CLOCK_SELECT_BIT] = wakeup_clock_select_r;
            read_mux[sysconf_pkg::WAKEUP_IRQ_ENABLE_BIT] = wakeup_irq_enable_r;
            read_mux[sysconf_pkg::WAKEUP_DELAY_LSB +: 3] = wakeup_delay_select_r;
         end
         default: begin
            read_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rdata_r <= 32'h0000_0000;
      end else if (bus_state_r == BUS_READ) begin
         rdata_r <= {24'h00_0000, read_mux};
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         watchdog_enable_r <= sysconf_pkg::SYSTEM_OPTIONS_RESET[2];
         watchdog_long_timeout_r <= sysconf_pkg::SYSTEM_OPTIONS_RESET[1];
         stop_allow_r <= sysconf_pkg::SYSTEM_OPTIONS_RESET[0];
      end else if (wr_en && addr_r == sysconf_pkg::OFS_SYSTEM_OPTIONS && !options_written_r) begin
         watchdog_enable_r <= wdata[sysconf_pkg::WATCHDOG_ENABLE_BIT];
         watchdog_long_timeout_r <= wdata[sysconf_pkg::WATCHDOG_LONG_TIMEOUT_BIT];
         stop_allow_r <= wdata[sysconf_pkg::STOP_ALLOW_BIT];
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         options_written_r <= 1'b0;
      end else if (wr_en && addr_r == sysconf_pkg::OFS_SYSTEM_OPTIONS) begin
         options_written_r <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         clock_out_pin_enable_r <= sysconf_pkg::CLOCK_OUTPUT_CONTROL_RESET[3];
         clock_out_divide_select_r <= sysconf_pkg::CLOCK_OUTPUT_CONTROL_RESET[2:0];
      end else if (wr_en && addr_r == sysconf_pkg::OFS_CLOCK_OUTPUT_CONTROL) begin
         clock_out_pin_enable_r <= wdata[sysconf_pkg::CLOCK_OUT_PIN_ENABLE_BIT];
         clock_out_divide_select_r <= wdata[sysconf_pkg::CLOCK_OUT_DIVIDE_LSB +: 3];
      end
   end

   // clock select, irq enable, delay select
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wakeup_clock_select_r <= sysconf_pkg::WAKEUP_CONTROL_RESET[4];
         wakeup_irq_enable_r <= sysconf_pkg::WAKEUP_CONTROL_RESET[3];
         wakeup_delay_select_r <= sysconf_pkg::WAKEUP_CONTROL_RESET[2:0];
      end else if (wr_en && addr_r == sysconf_pkg::OFS_PERIODIC_WAKEUP_CONTROL) begin
         // bit 3 and flag bit not stored
         wakeup_clock_select_r <= wdata[sysconf_pkg::WAKEUP_CLOCK_SELECT_BIT];
         wakeup_irq_enable_r <= wdata[sysconf_pkg::WAKEUP_IRQ_ENABLE_BIT];
         wakeup_delay_select_r <= wdata[sysconf_pkg::WAKEUP_DELAY_LSB +: 3];
      end
   end

   // wakeup clocks come from pins; first stage read only by second
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lpo_sync_r <= 3'h0;
         xtal_sync_r <= 3'h0;
      end else begin
         lpo_sync_r <= {lpo_sync_r[1:0], LPO_CLK_I};
         xtal_sync_r <= {xtal_sync_r[1:0], XTAL_CLK_I};
      end
   end

   // rising edge of the chosen source
   assign tick = wakeup_clock_select_r ? (xtal_sync_r[1] && !xtal_sync_r[2])
                                       : (lpo_sync_r[1] && !lpo_sync_r[2]);

   // period minus one, in source edges
   always_comb begin
      wake_last = '0;
      case ({wakeup_clock_select_r, wakeup_delay_select_r})
         4'b0_001: wake_last = 15'(sysconf_pkg::WAKE_MS_1 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_010: wake_last = 15'(sysconf_pkg::WAKE_MS_2 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_011: wake_last = 15'(sysconf_pkg::WAKE_MS_3 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_100: wake_last = 15'(sysconf_pkg::WAKE_MS_4 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_101: wake_last = 15'(sysconf_pkg::WAKE_MS_5 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_110: wake_last = 15'(sysconf_pkg::WAKE_MS_6 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b0_111: wake_last = 15'(sysconf_pkg::WAKE_MS_7 * sysconf_pkg::LPO_FREQ_KHZ - 1);
         4'b1_001: wake_last = 15'(sysconf_pkg::WAKE_XTAL_1 - 1);
         4'b1_010: wake_last = 15'(sysconf_pkg::WAKE_XTAL_2 - 1);
         4'b1_011: wake_last = 15'(sysconf_pkg::WAKE_XTAL_3 - 1);
         4'b1_100: wake_last = 15'(sysconf_pkg::WAKE_XTAL_4 - 1);
         4'b1_101: wake_last = 15'(sysconf_pkg::WAKE_XTAL_5 - 1);
         4'b1_110: wake_last = 15'(sysconf_pkg::WAKE_XTAL_6 - 1);
         4'b1_111: wake_last = 15'(sysconf_pkg::WAKE_XTAL_7 - 1);
         default: wake_last = '0;
      endcase
   end

   assign wake_timeout = tick && (wake_count_r == wake_last)
                         && (wakeup_delay_select_r != 3'h0);

   // select zero holds the timer; rewriting the control restarts it
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wake_count_r <= '0;
      end else if (wakeup_delay_select_r == 3'h0 || wake_timeout
                   || (wr_en && addr_r == sysconf_pkg::OFS_PERIODIC_WAKEUP_CONTROL)) begin
         wake_count_r <= '0;
      end else if (tick) begin
         wake_count_r <= wake_count_r + 15'h0001;
      end
   end

   // flag set on timeout; set beats a same-cycle ack
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wakeup_timeout_flag_r <= 1'b0;
      end else if (wake_timeout) begin
         wakeup_timeout_flag_r <= 1'b1;
      end else if (wr_en && addr_r == sysconf_pkg::OFS_PERIODIC_WAKEUP_CONTROL
                   && wdata[sysconf_pkg::WAKEUP_TIMEOUT_ACK_BIT]) begin
         wakeup_timeout_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= wakeup_timeout_flag_r && wakeup_irq_enable_r;
      end
   end

   // stop attempt enters stop or forces illegal-opcode reset
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         stop_enter_r <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         stop_enter_r <= STOP_EXEC_I && stop_allow_r;
         illegal_r <= STOP_EXEC_I && !stop_allow_r;
      end
   end

   // divided bus clock to the pin
   clock_out_divider u_clock_out_divider (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .enable_i(clock_out_pin_enable_r),
      .divide_i(clock_out_divide_select_r),
      .clk_out_o(CLOCK_OUT_PORT_PIN_O),
      .drive_n_o(CLOCK_OUT_PORT_PIN_OE_N_O)
   );

   // response is always okay; held in a flop so the output is registered
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         HRESP_O <= 1'b0;
      end else begin
         HRESP_O <= 1'b0;
      end
   end

   assign HRDATA_O = rdata_r;
   assign HREADYOUT_O = ready_r;
   assign WATCHDOG_ENABLE_O = watchdog_enable_r;
   assign WATCHDOG_LONG_TIMEOUT_O = watchdog_long_timeout_r;
   assign STOP_ALLOW_O = stop_allow_r;
   assign STOP_ENTER_O = stop_enter_r;
   assign ILLEGAL_OPCODE_RESET_O = illegal_r;
   assign WAKEUP_IRQ_O = irq_r;
endmodule : system_options_wakeup_clkout

// ---- system_options_wakeup_clkout_sva.sv ----
// assertions for the system configuration block, bound to its top module
// assumes one clock domain and a single AHB-Lite master looping hready back
`timescale 1ns/1ps
module system_options_wakeup_clkout_sva (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic STOP_EXEC_I,
   input wire logic WATCHDOG_ENABLE_O,
   input wire logic WATCHDOG_LONG_TIMEOUT_O,
   input wire logic STOP_ALLOW_O,
   input wire logic STOP_ENTER_O,
   input wire logic ILLEGAL_OPCODE_RESET_O,
   input wire logic CLOCK_OUT_PORT_PIN_O,
   input wire logic CLOCK_OUT_PORT_PIN_OE_N_O
);
   logic opt_wr_r;
   logic opt_done_r;
   // options write in its data phase
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         opt_wr_r <= 1'b0;
      end else begin
         opt_wr_r <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I && HADDR_I[7:0] == 8'h00;
      end
   end
   // set once the first options write has landed
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         opt_done_r <= 1'b0;
      end else begin
         opt_done_r <= opt_done_r | opt_wr_r;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_taken;
      HSEL_I && HTRANS_I[1] && HREADY_I;
   endsequence
   sequence s_one_wait;
      !HREADYOUT_O ##1 HREADYOUT_O;
   endsequence
   a_read_wait: assert property (s_taken and !HWRITE_I |=> s_one_wait)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (s_taken and HWRITE_I |=> HREADYOUT_O)
      else $error("write data phase stalled");
   a_options_frozen: assert property (opt_done_r |=> $stable({WATCHDOG_ENABLE_O,
      WATCHDOG_LONG_TIMEOUT_O, STOP_ALLOW_O}))
      else $error("options changed after first write");
   a_reset_defaults: assert property ($rose(RESET_N_I) |-> WATCHDOG_ENABLE_O &&
      WATCHDOG_LONG_TIMEOUT_O && !STOP_ALLOW_O)
      else $error("options outputs not at reset values");
   a_stop_allowed: assert property (STOP_EXEC_I && STOP_ALLOW_O |=> STOP_ENTER_O
      && !ILLEGAL_OPCODE_RESET_O) else $error("allowed stop not entered");
   a_stop_illegal: assert property (STOP_EXEC_I && !STOP_ALLOW_O |=> ILLEGAL_OPCODE_RESET_O
      && !STOP_ENTER_O) else $error("disallowed stop did not force reset");
   a_stop_quiet: assert property (!STOP_EXEC_I |=> !STOP_ENTER_O && !ILLEGAL_OPCODE_RESET_O)
      else $error("stop outputs pulsed without request");
   a_pin_idle_low: assert property (CLOCK_OUT_PORT_PIN_OE_N_O &&
      $past(CLOCK_OUT_PORT_PIN_OE_N_O) |-> !CLOCK_OUT_PORT_PIN_O)
      else $error("clock pin toggles while disabled");
   a_rdata_upper: assert property (HRDATA_O[31:8] == 24'h00_0000 && !HRESP_O)
      else $error("read data upper bits or response wrong");
endmodule : system_options_wakeup_clkout_sva
bind system_options_wakeup_clkout system_options_wakeup_clkout_sva i_sva (.*);

// ---- system_options_wakeup_clkout_tb_top.sv ----
// self-checking bench for the system configuration block
// assumes the block is the only AHB-Lite slave; wakeup sources are driven slowly here
`timescale 1ns/1ps
module system_options_wakeup_clkout_tb_top;
   logic clk, reset_n, hsel, hwrite, hreadyout, hresp, lpo, xtal, stop;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic wd_en, wd_long, stop_ok, stop_enter, ill_rst, pin, oe_n, irq;
   int num_errors;
   int checks;
   system_options_wakeup_clkout i_system_options_wakeup_clkout (
      .CLK_I(clk), .RESET_N_I(reset_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
      .LPO_CLK_I(lpo), .XTAL_CLK_I(xtal), .STOP_EXEC_I(stop),
      .WATCHDOG_ENABLE_O(wd_en), .WATCHDOG_LONG_TIMEOUT_O(wd_long), .STOP_ALLOW_O(stop_ok),
      .STOP_ENTER_O(stop_enter), .ILLEGAL_OPCODE_RESET_O(ill_rst),
      .CLOCK_OUT_PORT_PIN_O(pin), .CLOCK_OUT_PORT_PIN_OE_N_O(oe_n), .WAKEUP_IRQ_O(irq));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : chk
   // one single word transfer; read data taken at the edge that ends it
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [7:0] wd);
      logic [31:0] d;
      xfer(1'b1, a, wd, d);
   endtask : wr
   task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      logic [31:0] d;
      xfer(1'b0, a, 8'h00, d);
      chk(nm, {24'h00_0000, exp}, d & {24'h00_0000, m});
   endtask : rchk
   task rst;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
   endtask : rst
   task stop_try(input logic ok);
      @(posedge clk);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      @(posedge clk);
      chk("stop_enter", {31'h0, ok}, {31'h0, stop_enter});
      chk("illegal_reset", {31'h0, !ok}, {31'h0, ill_rst});
   endtask : stop_try
   task clkout(input logic [2:0] sel);
      int hi;
      int lo;
      wr(8'h04, {4'h1, 1'b0, sel});
      // divider restarts low one cycle after the select lands; skip old phase
      repeat (2) @(posedge clk);
      hi = 0;
      lo = 0;
      while (pin !== 1'b1) @(posedge clk);
      while (pin === 1'b1) begin
         hi++;
         @(posedge clk);
      end
      while (pin === 1'b0) begin
         lo++;
         @(posedge clk);
      end
      chk("clk_high", {29'h0, sel}, 32'(hi));
      chk("clk_low", {29'h0, sel}, 32'(lo));
      chk("oe_n", 32'h0000_0000, {31'h0, oe_n});
   endtask : clkout
   task pulses(input logic cs, input int n);
      repeat (n) begin
         if (cs) xtal <= 1'b1;
         else lpo <= 1'b1;
         repeat (10) @(posedge clk);
         lpo <= 1'b0;
         xtal <= 1'b0;
         repeat (10) @(posedge clk);
      end
   endtask : pulses
   task wake(input logic cs, input logic ie, input logic [2:0] code, input int n);
      logic [7:0] v;
      v = {2'b00, cs, ie, 1'b0, code};
      wr(8'h10, v);
      pulses(cs, n - 1);
      rchk("flag_early", 8'h10, v, 8'hff);
      pulses(cs, 1);
      rchk("flag_set", 8'h10, v | 8'h80, 8'hff);
      chk("irq", {31'h0, ie}, {31'h0, irq});
      wr(8'h10, v | 8'h40);
      rchk("flag_ack", 8'h10, v, 8'hff);
      chk("irq_ack", 32'h0000_0000, {31'h0, irq});
   endtask : wake
   initial begin
      #800_000;
      num_errors++;
      end_sim();
   end
   initial begin
      reset_n = 1'b0;
      {hsel, hwrite, lpo, xtal, stop} = 5'h00;
      {haddr, hwdata} = 64'h0000_0000_0000_0000;
      htrans = 2'b00;
      hsize = 3'b010;
      num_errors = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rchk("options", 8'h00, 8'hc0, 8'hfc);
      rchk("clock_out", 8'h04, 8'h00, 8'hff);
      rchk("wakeup", 8'h10, 8'h00, 8'hff);
      rchk("id_high", 8'h08, {4'h0, sysconf_pkg::PART_NUMBER[11:8]}, 8'h0f);
      rchk("id_low", 8'h0c, sysconf_pkg::PART_NUMBER[7:0], 8'hff);
      rchk("unmapped", 8'h14, 8'h00, 8'hff);
      stop_try(1'b0);
      $display("test reset_values done");
      wr(8'h00, 8'hff);
      rchk("options_first", 8'h00, 8'he0, 8'hfc);
      wr(8'h00, 8'h00);
      rchk("options_second", 8'h00, 8'he0, 8'hfc);
      stop_try(1'b1);
      wr(8'h08, 8'hff);
      wr(8'h0c, 8'h00);
      rchk("id_high_wr", 8'h08, {4'h0, sysconf_pkg::PART_NUMBER[11:8]}, 8'h0f);
      rchk("id_low_wr", 8'h0c, sysconf_pkg::PART_NUMBER[7:0], 8'hff);
      rst();
      rchk("options_rst", 8'h00, 8'hc0, 8'hfc);
      wr(8'h00, 8'h40);
      // outputs update at the edge that ends the write
      @(posedge clk);
      chk("wd_enable", 32'h0000_0000, {31'h0, wd_en});
      chk("wd_long", 32'h0000_0001, {31'h0, wd_long});
      $display("test write_once done");
      for (int s = 1; s < 8; s++) clkout(3'(s));
      wr(8'h04, 8'h10);
      // select reaches the divider one cycle after the register
      @(posedge clk);
      repeat (20) begin
         @(posedge clk);
         chk("pin_low", 32'h0000_0000, {31'h0, pin});
      end
      rchk("clock_out_rd", 8'h04, 8'h10, 8'hff);
      wr(8'h04, 8'h00);
      repeat (2) @(posedge clk);
      chk("oe_n_off", 32'h0000_0001, {31'h0, oe_n});
      $display("test clock_out done");
      wake(1'b0, 1'b1, 3'd1, 8);
      wake(1'b0, 1'b1, 3'd2, 32);
      wake(1'b0, 1'b0, 3'd3, 64);
      wake(1'b1, 1'b1, 3'd1, 256);
      wake(1'b1, 1'b1, 3'd2, 1024);
      wr(8'h10, 8'h18);
      rchk("wakeup_unimpl", 8'h10, 8'h10, 8'hff);
      pulses(1'b0, 20);
      rchk("wakeup_off", 8'h10, 8'h10, 8'hff);
      chk("irq_off", 32'h0000_0000, {31'h0, irq});
      $display("test wakeup done");
      end_sim();
   end
endmodule : system_options_wakeup_clkout_tb_top
